/* seap_pkg.sv */
// Constants, state type and the write-protect decode of the serial EEPROM block.
// Assumes a single user module that imports everything from here.
package seap_pkg;

   localparam int          SEAP_ADDR_W       = 8;
   localparam int          SEAP_DEPTH        = 256;
   localparam int          SEAP_PAGE_BYTES   = 4;
   localparam logic [7:0]  SEAP_ADDR_RESET   = 8'h00;
   localparam logic [7:0]  SEAP_ERASED       = 8'hFF;
   localparam logic [3:0]  SEAP_CHIP_FIXED   = 4'hA;
   localparam logic [7:0]  SEAP_OP_READ      = 8'hA7;
   localparam logic [7:0]  SEAP_OP_VPP_ON    = 8'hA6;
   localparam logic [7:0]  SEAP_OP_VPP_OFF   = 8'hA4;
   localparam logic [7:0]  SEAP_OP_WRITE     = 8'hA2;
   localparam logic [7:0]  SEAP_PROT_ADDR    = 8'hFF;
   localparam int          SEAP_PROT_HI      = 3;
   localparam int          SEAP_PROT_LO      = 2;
   localparam logic [7:0]  SEAP_PROT_LOW_1   = 8'hC0;
   localparam logic [7:0]  SEAP_PROT_LOW_2   = 8'h80;
   localparam logic [7:0]  SEAP_PROT_LOW_3   = 8'h40;
   localparam logic [7:0]  SEAP_PROT_TOP     = 8'hFB;
   localparam logic [3:0]  SEAP_BIT_ACK      = 4'h8;
   localparam logic [2:0]  SEAP_SPI_LAST     = 3'h7;
   localparam logic [1:0]  SEAP_IDX_SAT      = 2'h3;

   // Two-wire framing states.
   typedef enum logic [1:0] {
      SEAP_TW_IDLE,
      SEAP_TW_ADDR,
      SEAP_TW_WR,
      SEAP_TW_RD
   } seap_tw_state_t;

   // True when the protect byte blocks a write to this address; the top bytes stay free.
   function automatic logic seap_is_protected(input logic [7:0] a, input logic [7:0] ctrl);
      logic [7:0] low;
      logic       on;
      low = SEAP_PROT_TOP;
      on  = 1'b1;
      case (ctrl[SEAP_PROT_HI:SEAP_PROT_LO])
         2'h1:    low = SEAP_PROT_LOW_1;
         2'h2:    low = SEAP_PROT_LOW_2;
         2'h3:    low = SEAP_PROT_LOW_3;
         default: on  = 1'b0;
      endcase
      return on && (a >= low) && (a <= SEAP_PROT_TOP);
   endfunction : seap_is_protected

endpackage : seap_pkg

/* seap_top.sv */
// Serial EEPROM core: two-wire slave framing, four-wire opcode slave, page buffer,
// power-up write inhibit, voltage enable and array write protection.
// Assumes the master times programming and that straps change only in standby.
`timescale 1ns/1ps
`default_nettype none
module seap_top
   import seap_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       four_wire_mode,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_n,
   input  wire logic       chip_select_pin_low_bit,
   input  wire logic       chip_select_pin_high_bit,
   input  wire logic       select_in_low,
   input  wire logic       four_wire_clock_in,
   input  wire logic       four_wire_data_in,
   output logic            four_wire_data_out,
   output logic            four_wire_data_out_oe_n,
   output logic            standby,
   output logic            programming,
   output logic            vpp_generator_on,
   output logic            write_inhibited,
   output logic [7:0]      byte_address
);

   // Array contents survive reset, as nonvolatile cells would; the cells start out erased.
   logic [7:0] mem [SEAP_DEPTH] = '{default: SEAP_ERASED};

   // Pin synchronisers and edge history.
   logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
   logic csl_s1, csl_s2, csh_s1, csh_s2, mode_s1, mode_s2;
   logic sel_s1, sel_s2, sel_d, tgl_s1, tgl_s2, tgl_d;

   // Link-side state.
   logic [2:0] spi_cnt;
   logic [6:0] spi_sr;
   logic [7:0] tx_sh;
   logic       out_bit;
   logic [7:0] rx_hold;
   logic       rx_tgl;
   logic       spi_rst;

   // System-side state and next values.
   seap_tw_state_t tw_st, next_tw_st;
   logic [3:0] tw_cnt, next_tw_cnt;
   logic [7:0] tw_sr, next_tw_sr, tw_tx, next_tw_tx;
   logic       tw_ack_ph, next_tw_ack_ph, tw_first, next_tw_first;
   logic       tw_mack, next_tw_mack, sda_drv, next_sda_drv;
   logic [7:0] addr, next_addr, fw_tx, next_fw_tx;
   logic       inhibit, next_inhibit, prog_active, next_prog_active;
   logic       vpp_en, next_vpp_en, pending, next_pending;
   logic [7:0] buf_data [SEAP_PAGE_BYTES];
   logic [7:0] next_buf_data [SEAP_PAGE_BYTES];
   logic [3:0] buf_valid, next_buf_valid;
   logic [5:0] buf_page, next_buf_page;
   logic [1:0] fw_idx, next_fw_idx;
   logic       fw_armed, next_fw_armed, fw_bad, next_fw_bad;
   logic       fw_rd, next_fw_rd, fw_wr, next_fw_wr;
   logic       fw_oe_n, next_fw_oe_n;
   logic       do_commit;

   logic scl_rise, scl_fall, start_seen, stop_seen, sel_fall, sel_rise, fw_byte, chip_match;

   // Every strap, two-wire and select pin passes two flops, as does the link byte toggle; only the second one is looked at.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         scl_s1  <= 1'b1;
         scl_s2  <= 1'b1;
         scl_d   <= 1'b1;
         sda_s1  <= 1'b1;
         sda_s2  <= 1'b1;
         sda_d   <= 1'b1;
         csl_s1  <= 1'b0;
         csl_s2  <= 1'b0;
         csh_s1  <= 1'b0;
         csh_s2  <= 1'b0;
         mode_s1 <= 1'b0;
         mode_s2 <= 1'b0;
         sel_s1  <= 1'b1;
         sel_s2  <= 1'b1;
         sel_d   <= 1'b1;
         tgl_s1  <= 1'b0;
         tgl_s2  <= 1'b0;
         tgl_d   <= 1'b0;
      end else begin
         scl_s1  <= scl_in;
         scl_s2  <= scl_s1;
         scl_d   <= scl_s2;
         sda_s1  <= sda_in;
         sda_s2  <= sda_s1;
         sda_d   <= sda_s2;
         csl_s1  <= chip_select_pin_low_bit;
         csl_s2  <= csl_s1;
         csh_s1  <= chip_select_pin_high_bit;
         csh_s2  <= csh_s1;
         mode_s1 <= four_wire_mode;
         mode_s2 <= mode_s1;
         sel_s1  <= select_in_low;
         sel_s2  <= sel_s1;
         sel_d   <= sel_s2;
         tgl_s1  <= rx_tgl;
         tgl_s2  <= tgl_s1;
         tgl_d   <= tgl_s2;
      end
   end

   // Line events, all taken from the second synchroniser stage onward.
   assign scl_rise   = scl_s2 & ~scl_d;
   assign scl_fall   = ~scl_s2 & scl_d;
   assign start_seen = scl_s2 & scl_d & sda_d & ~sda_s2;
   assign stop_seen  = scl_s2 & scl_d & ~sda_d & sda_s2;
   assign sel_fall   = ~sel_s2 & sel_d;
   assign sel_rise   = sel_s2 & ~sel_d;
   assign fw_byte    = tgl_s2 ^ tgl_d;
   // Fifth bit is a don't care; the sixth and seventh bits must match the straps, and the last bit picks the direction.
   assign chip_match = (tw_sr[7:4] == SEAP_CHIP_FIXED) && (tw_sr[2:1] == {csh_s2, csl_s2});

   // The select pin itself ends a link frame, since the link clock stops between frames.
   assign spi_rst = rst | select_in_low;

   // Link-side bit counter and input shift, most significant bit first.
   always_ff @(posedge four_wire_clock_in or posedge spi_rst) begin
      if (spi_rst) begin
         spi_cnt <= 3'h0;
         spi_sr  <= 7'h00;
         tx_sh   <= 8'h00;
      end else begin
         spi_cnt <= 3'(spi_cnt + 3'h1);
         spi_sr  <= {spi_sr[5:0], four_wire_data_in};
         // The outgoing word is captured as a byte begins; it is held steady by mclk.
         tx_sh   <= (spi_cnt == 3'h0) ? {fw_tx[6:0], 1'b0} : {tx_sh[6:0], 1'b0};
      end
   end

   // A finished byte is held and flagged by a toggle, which survives the end of the frame.
   always_ff @(posedge four_wire_clock_in or posedge rst) begin
      if (rst) begin
         rx_hold <= 8'h00;
         rx_tgl  <= 1'b0;
      end else if (spi_cnt == SEAP_SPI_LAST && !select_in_low) begin
         rx_hold <= {spi_sr, four_wire_data_in};
         rx_tgl  <= ~rx_tgl;
      end
   end

   // Output bits change on the falling link clock edge.
   always_ff @(negedge four_wire_clock_in or posedge spi_rst) begin
      if (spi_rst) begin
         out_bit <= 1'b0;
      end else begin
         out_bit <= tx_sh[7];
      end
   end

   // Next-state logic for framing, opcodes, buffer, inhibit and programming.
   always_comb begin
      next_tw_st       = tw_st;
      next_tw_cnt      = tw_cnt;
      next_tw_sr       = tw_sr;
      next_tw_tx       = tw_tx;
      next_tw_ack_ph   = tw_ack_ph;
      next_tw_first    = tw_first;
      next_tw_mack     = tw_mack;
      next_sda_drv     = sda_drv;
      next_addr        = addr;
      next_fw_tx       = fw_tx;
      next_inhibit     = inhibit;
      next_prog_active = prog_active;
      next_vpp_en      = vpp_en;
      next_pending     = pending;
      next_buf_data    = buf_data;
      next_buf_valid   = buf_valid;
      next_buf_page    = buf_page;
      next_fw_idx      = fw_idx;
      next_fw_armed    = fw_armed;
      next_fw_bad      = fw_bad;
      next_fw_rd       = fw_rd;
      next_fw_wr       = fw_wr;
      next_fw_oe_n     = 1'b1;
      do_commit        = 1'b0;
      if (!mode_s2) begin
         if (start_seen || stop_seen) begin
            // A terminated write launches programming; no erase pass is needed.
            if (tw_st == SEAP_TW_WR && buf_valid != 4'h0 && !inhibit) begin
               do_commit        = 1'b1;
               next_prog_active = 1'b1;
            end
            if (tw_st == SEAP_TW_WR) begin
               next_buf_valid = 4'h0;
            end
            next_sda_drv   = 1'b0;
            next_tw_cnt    = 4'h0;
            next_tw_ack_ph = 1'b0;
            next_tw_st     = start_seen ? SEAP_TW_ADDR : SEAP_TW_IDLE;
         end else if (tw_st != SEAP_TW_IDLE) begin
            if (scl_rise) begin
               if (tw_ack_ph) begin
                  next_tw_mack = ~sda_s2;
               end else begin
                  next_tw_sr  = {tw_sr[6:0], sda_s2};
                  next_tw_cnt = 4'(tw_cnt + 4'h1);
               end
            end
            if (scl_fall) begin
               if (tw_ack_ph) begin
                  next_tw_ack_ph = 1'b0;
                  next_tw_cnt    = 4'h0;
                  next_sda_drv   = 1'b0;
                  if (tw_st == SEAP_TW_RD) begin
                     if (tw_mack) begin
                        next_tw_tx   = mem[addr];
                        next_sda_drv = ~mem[addr][7];
                     end else begin
                        // No master acknowledge: release the line and leave the read.
                        next_tw_st   = SEAP_TW_IDLE;
                        next_inhibit = 1'b0;
                     end
                  end
               end else if (tw_cnt == SEAP_BIT_ACK) begin
                  next_tw_ack_ph = 1'b1;
                  case (tw_st)
                     SEAP_TW_ADDR: begin
                        if (chip_match) begin
                           next_prog_active = 1'b0;
                           next_sda_drv     = 1'b1;
                           next_tw_mack     = 1'b1;
                           if (tw_sr[0]) begin
                              next_tw_st = SEAP_TW_RD;
                              next_tw_tx = mem[addr];
                           end else begin
                              next_tw_st     = SEAP_TW_WR;
                              next_tw_first  = 1'b1;
                              next_buf_valid = 4'h0;
                           end
                        end else begin
                           // Other chips' traffic leaves programming running.
                           next_tw_st = SEAP_TW_IDLE;
                        end
                     end
                     SEAP_TW_WR: begin
                        next_sda_drv = 1'b1;
                        if (tw_first) begin
                           next_addr     = tw_sr;
                           next_buf_page = tw_sr[7:2];
                           next_tw_first = 1'b0;
                        end else begin
                           next_buf_data[addr[1:0]]  = tw_sr;
                           next_buf_valid[addr[1:0]] = 1'b1;
                           next_addr = {addr[7:2], 2'(addr[1:0] + 2'h1)};
                        end
                     end
                     SEAP_TW_RD: begin
                        next_sda_drv = 1'b0;
                        next_tw_mack = 1'b0;
                        next_addr    = 8'(addr + 8'h01);
                     end
                     default: begin
                        next_tw_st = SEAP_TW_IDLE;
                     end
                  endcase
               end else if (tw_st == SEAP_TW_RD) begin
                  next_sda_drv = ~tw_tx[3'(4'h7 - tw_cnt)];
               end
            end
         end
      end else begin
         if (sel_fall) begin
            next_fw_idx   = 2'h0;
            next_fw_armed = 1'b1;
            next_fw_bad   = 1'b0;
            next_fw_rd    = 1'b0;
            next_fw_wr    = 1'b0;
            next_fw_tx    = addr;
         end
         if (sel_rise && fw_wr) begin
            next_fw_wr = 1'b0;
            if (buf_valid != 4'h0) begin
               next_pending = 1'b1;
            end
         end
         if (fw_byte && fw_armed && !fw_bad) begin
            if (fw_idx == 2'h0) begin
               case (rx_hold)
                  SEAP_OP_READ: begin
                     next_fw_rd   = 1'b1;
                     next_inhibit = 1'b0;
                  end
                  SEAP_OP_VPP_ON: begin
                     next_vpp_en = 1'b1;
                  end
                  SEAP_OP_VPP_OFF: begin
                     next_vpp_en      = 1'b0;
                     next_prog_active = 1'b0;
                  end
                  SEAP_OP_WRITE: begin
                     next_fw_wr     = 1'b1;
                     next_pending   = 1'b0;
                     next_buf_valid = 4'h0;
                  end
                  default: begin
                     next_fw_bad = 1'b1;
                  end
               endcase
            end else if (fw_idx == 2'h1) begin
               if (fw_rd || fw_wr) begin
                  next_addr     = rx_hold;
                  next_buf_page = rx_hold[7:2];
               end
               if (fw_rd) begin
                  next_fw_tx = mem[rx_hold];
               end
            end else if (fw_wr) begin
               next_buf_data[addr[1:0]]  = rx_hold;
               next_buf_valid[addr[1:0]] = 1'b1;
               next_addr = {addr[7:2], 2'(addr[1:0] + 2'h1)};
            end else if (fw_rd && fw_idx == SEAP_IDX_SAT) begin
               next_addr  = 8'(addr + 8'h01);
               next_fw_tx = mem[8'(addr + 8'h01)];
            end
            if (fw_idx != SEAP_IDX_SAT) begin
               next_fw_idx = 2'(fw_idx + 2'h1);
            end
         end
         // Programming needs both a finished write and the enable, in either order.
         if (pending && vpp_en && !inhibit) begin
            do_commit        = 1'b1;
            next_prog_active = 1'b1;
            next_pending     = 1'b0;
            next_buf_valid   = 4'h0;
         end
         next_fw_oe_n = sel_s2 | fw_bad | ~fw_armed;
      end
   end

   // System-side registers; reset gives standby, no programming, address zero, hi-Z lines.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tw_st       <= SEAP_TW_IDLE;
         tw_cnt      <= 4'h0;
         tw_sr       <= 8'h00;
         tw_tx       <= 8'h00;
         tw_ack_ph   <= 1'b0;
         tw_first    <= 1'b0;
         tw_mack     <= 1'b0;
         sda_drv     <= 1'b0;
         addr        <= SEAP_ADDR_RESET;
         fw_tx       <= SEAP_ADDR_RESET;
         inhibit     <= 1'b1;
         prog_active <= 1'b0;
         vpp_en      <= 1'b0;
         pending     <= 1'b0;
         buf_valid   <= 4'h0;
         buf_page    <= 6'h00;
         fw_idx      <= 2'h0;
         fw_armed    <= 1'b0;
         fw_bad      <= 1'b0;
         fw_rd       <= 1'b0;
         fw_wr       <= 1'b0;
         fw_oe_n     <= 1'b1;
         for (int i = 0; i < SEAP_PAGE_BYTES; i++) begin
            buf_data[i] <= 8'h00;
         end
      end else begin
         tw_st       <= next_tw_st;
         tw_cnt      <= next_tw_cnt;
         tw_sr       <= next_tw_sr;
         tw_tx       <= next_tw_tx;
         tw_ack_ph   <= next_tw_ack_ph;
         tw_first    <= next_tw_first;
         tw_mack     <= next_tw_mack;
         sda_drv     <= next_sda_drv;
         addr        <= next_addr;
         fw_tx       <= next_fw_tx;
         inhibit     <= next_inhibit;
         prog_active <= next_prog_active;
         vpp_en      <= next_vpp_en;
         pending     <= next_pending;
         buf_valid   <= next_buf_valid;
         buf_page    <= next_buf_page;
         fw_idx      <= next_fw_idx;
         fw_armed    <= next_fw_armed;
         fw_bad      <= next_fw_bad;
         fw_rd       <= next_fw_rd;
         fw_wr       <= next_fw_wr;
         fw_oe_n     <= next_fw_oe_n;
         buf_data    <= next_buf_data;
      end
   end

   // The buffered page is written straight over the old value, skipping protected bytes.
   // The protect byte is read as it stood before this commit lands.
   always_ff @(posedge mclk) begin
      if (do_commit) begin
         for (int i = 0; i < SEAP_PAGE_BYTES; i++) begin
            if (buf_valid[i] && !seap_is_protected({buf_page, 2'(i)}, mem[SEAP_PROT_ADDR])) begin
               mem[{buf_page, 2'(i)}] <= buf_data[i];
            end
         end
      end
   end

   // The open-drain line only ever pulls low; the first link bit comes straight from mclk.
   assign sda_out                 = 1'b0;
   assign sda_oe_n                = ~sda_drv;
   assign four_wire_data_out      = (spi_cnt == 3'h0) ? fw_tx[7] : out_bit;
   assign four_wire_data_out_oe_n = fw_oe_n;
   // The generator follows programming in two-wire mode and the enable flag otherwise.
   assign vpp_generator_on        = mode_s2 ? vpp_en : prog_active;
   assign programming             = prog_active;
   assign write_inhibited         = inhibit;
   assign byte_address            = addr;
   assign standby = mode_s2 ? (sel_s2 && !pending && !vpp_en)
                            : (tw_st == SEAP_TW_IDLE && !prog_active);

endmodule : seap_top
`default_nettype wire

/* seap_checker.sv */
// Port checks of the serial EEPROM core, bound to every seap_top.
// Assumes all checked outputs belong to the mclk domain.
`timescale 1ns/1ps
`default_nettype none
module seap_checker (
   input wire logic       mclk,
   input wire logic       rst,
   input wire logic       four_wire_mode,
   input wire logic       scl_in,
   input wire logic       select_in_low,
   input wire logic       sda_oe_n,
   input wire logic       four_wire_data_out_oe_n,
   input wire logic       standby,
   input wire logic       programming,
   input wire logic       vpp_generator_on,
   input wire logic       write_inhibited,
   input wire logic [7:0] byte_address
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // Pins pass two flops, so idle windows are a few cycles long before outputs must settle.
   a_vpp_tracks_prog: assert property (!four_wire_mode |-> vpp_generator_on == programming)
      else $error("vpp and programming differ in two-wire mode");
   a_inhibit_stays: assert property (!write_inhibited |=> !write_inhibited)
      else $error("write inhibit came back without reset");
   a_prog_not_idle: assert property (programming |-> !standby)
      else $error("standby while programming");
   a_prog_has_vpp: assert property (programming |-> vpp_generator_on || $past(vpp_generator_on))
      else $error("programming without program voltage");
   a_addr_hold: assert property ((!four_wire_mode && $stable(scl_in))[*8] |-> $stable(byte_address))
      else $error("byte address moved with the bus clock still");
   a_fw_out_quiet: assert property ((four_wire_mode && select_in_low)[*6] |-> four_wire_data_out_oe_n)
      else $error("four-wire output driven while deselected");
   a_fw_off_tw: assert property ((!four_wire_mode)[*4] |-> four_wire_data_out_oe_n)
      else $error("four-wire output driven in two-wire mode");
   a_sda_off_fw: assert property (four_wire_mode[*6] |-> sda_oe_n)
      else $error("two-wire data pulled in four-wire mode");
   c_prog: cover property ($rose(programming));
   c_inhibit_off: cover property ($fell(write_inhibited));
   c_fw_vpp: cover property (four_wire_mode && vpp_generator_on);
endmodule : seap_checker
bind seap_top seap_checker i_chk (.mclk, .rst, .four_wire_mode, .scl_in, .select_in_low,
   .sda_oe_n, .four_wire_data_out_oe_n, .standby, .programming, .vpp_generator_on,
   .write_inhibited, .byte_address);
`default_nettype wire

/* seap_master.sv */
// Bus master model for both serial modes, called by the bench one task at a time.
// Assumes a pull-up on the two-wire data line, resolved by the bench.
`timescale 1ns/1ps
`default_nettype none
module seap_master (
   input  wire logic mclk,
   input  wire logic sda_oe_n,
   input  wire logic fw_dout,
   output logic      scl,
   output logic      sda_drv,
   output logic      fw_clk,
   output logic      fw_sel_n,
   output logic      fw_din
);
   // Idle levels; the link clock stands low outside frames.
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
      fw_clk = 1'b0;
      fw_sel_n = 1'b1;
      fw_din = 1'b0;
   end
   // Six cycles per phase keeps each clock phase longer than the two synchroniser flops on every two-wire pin.
   task automatic hp;
      repeat (6) @(posedge mclk);
   endtask : hp
   task automatic bit_x(input logic b, output logic r);
      sda_drv <= b;
      hp();
      scl <= 1'b1;
      hp();
      @(negedge mclk) r = sda_drv & sda_oe_n;
      @(posedge mclk) scl <= 1'b0;
      hp();
   endtask : bit_x
   // Eight bits, first bit the most significant, then the acknowledge slot.
   task automatic xfer(input logic [7:0] d, input logic am, output logic [7:0] q,
                       output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], q[i]);
      end
      bit_x(am, ack); // A high slot ends a read, which also lifts the inhibit.
   endtask : xfer
   task automatic start;
      sda_drv <= 1'b1;
      hp();
      scl <= 1'b1;
      hp();
      sda_drv <= 1'b0;
      hp();
      scl <= 1'b0;
      hp();
   endtask : start
   // Programming is left running until the bench selects the chip again.
   task automatic stop;
      sda_drv <= 1'b0;
      hp();
      scl <= 1'b1;
      hp();
      sda_drv <= 1'b1;
      hp();
   endtask : stop
   // Four-wire frame of n bytes from d, top byte first; q keeps the last byte read.
   task automatic fw_frame(input logic [31:0] d, input int n, output logic [7:0] q);
      @(posedge mclk) fw_sel_n <= 1'b0;
      repeat (4) @(posedge mclk);
      #3;
      for (int k = 0; k < n; k++) begin
         for (int i = 7; i >= 0; i--) begin
            fw_din = d[8 * (3 - k) + i];
            #6 q[i] = fw_dout;
            fw_clk = 1'b1;
            #6 fw_clk = 1'b0;
         end
      end
      @(posedge mclk) fw_sel_n <= 1'b1;
      repeat (8) @(posedge mclk);
   endtask : fw_frame
endmodule : seap_master
`default_nettype wire

/* tb_top.sv */
// Self-checking bench of the serial EEPROM core in both serial modes.
// Assumes seap_master drives every serial pin; the chip-select straps are random but fixed, and the mode strap is switched once.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic       mclk = 1'b0;
   logic       rst = 1'b1;
   logic       four_wire_mode = 1'b0;
   logic [1:0] cs = 2'h0;
   logic       scl, sda_drv, sda_oe_n, select_in_low, four_wire_clock_in, four_wire_data_in;
   logic       four_wire_data_out, four_wire_data_out_oe_n, standby, programming;
   logic       vpp_generator_on, write_inhibited, inh, ack, sda_out;
   logic [7:0] byte_address, q, ra, d;
   logic [7:0] mem [256];
   int         errors = 0;
   int         num_checks = 0;
   // Pull-up wire-and; a released four-wire output shows a toggling level.
   wire        sda = sda_drv & (sda_oe_n | sda_out);
   wire        fw_do = four_wire_data_out_oe_n ? mclk : four_wire_data_out;
   always #5 mclk = ~mclk;
   seap_top i_dut (.mclk, .rst, .four_wire_mode, .scl_in(scl), .sda_in(sda), .sda_out,
      .sda_oe_n, .chip_select_pin_low_bit(cs[0]), .chip_select_pin_high_bit(cs[1]),
      .select_in_low, .four_wire_clock_in, .four_wire_data_in, .four_wire_data_out,
      .four_wire_data_out_oe_n, .standby, .programming, .vpp_generator_on,
      .write_inhibited, .byte_address);
   seap_master m (.mclk, .sda_oe_n(sda_oe_n | sda_out), .fw_dout(fw_do), .scl, .sda_drv,
      .fw_clk(four_wire_clock_in), .fw_sel_n(select_in_low), .fw_din(four_wire_data_in));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic print_verdict;
      $display("checks=%0d errors=%0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : print_verdict
   // Chip address with a random don't-care bit; the last bit picks the direction.
   function automatic logic [7:0] dev(input logic rw);
      return {4'hA, 1'($urandom), cs, rw};
   endfunction : dev
   function automatic logic [7:0] lowof(input logic [1:0] f);
      return (f == 2'h1) ? 8'hC0 : (f == 2'h2) ? 8'h80 : 8'h40;
   endfunction : lowof
   // The top four bytes stay writable, so the control byte can be changed whenever writes are not inhibited.
   function automatic logic blocked(input logic [7:0] a);
      return inh || (mem[255][3:2] != 2'h0 && a >= lowof(mem[255][3:2]) && a <= 8'hFB);
   endfunction : blocked
   task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic st);
      logic b;
      b = blocked(a);
      m.start();
      m.xfer(dev(1'b0), 1'b1, q, ack);
      chk(8'(ack), 8'h0);
      m.xfer(a, 1'b1, q, ack);
      chk(byte_address, a);
      m.xfer(v, 1'b1, q, ack);
      if (st) m.start();
      else m.stop();
      if (!b) chk(8'({programming, vpp_generator_on}), 8'h3);
      if (!b) mem[a] = v;
      if (st) m.stop();
   endtask : wr
   task automatic rd(input logic [7:0] a);
      m.start();
      m.xfer(dev(1'b0), 1'b1, q, ack);
      m.xfer(a, 1'b1, q, ack);
      m.start();
      m.xfer(dev(1'b1), 1'b1, q, ack);
      chk(8'(programming), 8'h0);
      m.xfer(8'hFF, 1'b0, q, ack);
      chk(q, mem[a]);
      m.xfer(8'hFF, 1'b1, q, ack);
      chk(q, mem[a + 8'h1]);
      m.stop();
      inh = 1'b0;
      chk(8'({write_inhibited, standby}), 8'h1);
      chk(byte_address, a + 8'h2);
   endtask : rd
   // Hang guard, about three times the expected run of some fourteen thousand cycles.
   initial begin
      #400_000;
      errors++;
      print_verdict();
   end
   // Main sequence: two-wire traffic, protect modes, then the four-wire link.
   initial begin
      void'($urandom(86765));
      foreach (mem[i]) mem[i] = 8'hFF;
      inh = 1'b1;
      @(posedge mclk) cs <= 2'($urandom);
      @(posedge mclk) rst <= 1'b0;
      repeat (3) @(posedge mclk);
      chk(8'({standby, programming, vpp_generator_on, write_inhibited}), 8'h9);
      chk(byte_address, 8'h00);
      chk(8'({sda_oe_n, four_wire_data_out_oe_n}), 8'h3);
      wr(8'h10, 8'h00, 1'b0);
      rd(8'h10);
      ra = 8'h3F & 8'($urandom);
      wr(ra, 8'($urandom), 1'b1);
      m.start();
      m.xfer({4'hA, 1'b0, ~cs, 1'b0}, 1'b1, q, ack);
      chk(8'({ack, programming}), 8'h3);
      m.stop();
      rd(ra);
      for (int f = 0; f < 4; f++) begin
         wr(8'hFF, {4'($urandom), 2'(f), 2'($urandom)}, 1'($urandom));
         wr(lowof(2'(f)) - 8'h1, 8'($urandom), 1'($urandom));
         wr(lowof(2'(f)), 8'($urandom), 1'($urandom));
         rd(lowof(2'(f)) - 8'h1);
      end
      @(posedge mclk) four_wire_mode <= 1'b1;
      repeat (4) @(posedge mclk);
      d = 8'($urandom);
      m.fw_frame({8'hA7, ra, 16'h0}, 4, q);
      chk(q, mem[ra]);
      m.fw_frame({8'hA2, ra, d, 8'h0}, 3, q);
      chk(8'({programming, vpp_generator_on}), 8'h0);
      m.fw_frame({8'hA6, 24'h0}, 1, q);
      chk(8'({programming, vpp_generator_on}), 8'h3);
      m.fw_frame({8'hA4, 24'h0}, 1, q);
      chk(8'({vpp_generator_on, standby}), 8'h1);
      m.fw_frame({8'hA7, ra, 16'h0}, 4, q);
      chk(q, d);
      // An unknown opcode must leave the address byte that follows it unused.
      m.fw_frame({8'hA5, 8'h00, 16'h0}, 2, q);
      chk(byte_address, ra + 8'h1);
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
